// ### core/asfc_pkg.sv
// Purpose: Shared constants and types for the graphics port status and flow-control block
// Assumes: One clock (mclk), asynchronous active-high reset
// Notes:   Pin polarity depends on the signalling mode selected by mode_v3

package asfc_pkg;

   // Grant status codes as they appear on the pins in true (active-high) sense
   localparam logic [2:0] ST_LP_READ  = 3'h0;
   localparam logic [2:0] ST_HP_READ  = 3'h1;
   localparam logic [2:0] ST_LP_WRITE = 3'h2;
   localparam logic [2:0] ST_HP_WRITE = 3'h3;
   localparam logic [2:0] ST_START    = 3'h7;

   // Reset values of the pin-side registers in true sense
   localparam logic       GRANT_RST   = 1'h0;
   localparam logic [2:0] STATUS_RST  = 3'h7;

   // Reset values of the mode register, synchronisers and pin-side flops
   localparam logic       MODE_RST      = 1'h0;
   localparam logic [1:0] SYNC_RST      = 2'h0;
   localparam logic       GRANT_PIN_RST = 1'h1;  // Grant released at 2.0 polarity
   localparam logic       OE_ON         = 1'h1;

   // Request kinds offered by the arbitration core
   typedef enum logic [2:0] {
      ASFC_REQ_IDLE     = 3'h0,
      ASFC_REQ_LP_READ  = 3'h1,
      ASFC_REQ_HP_READ  = 3'h2,
      ASFC_REQ_LP_WRITE = 3'h3,
      ASFC_REQ_HP_WRITE = 3'h4,
      ASFC_REQ_START    = 3'h5,
      ASFC_REQ_FAST_WR  = 3'h6
   } asfc_req_t;

   // Master-side flow-control levels after synchronising, in true sense
   typedef struct packed {
      logic rd_full;
      logic wr_full;
   } asfc_flow_t;

endpackage

// ### core/asfc_top.sv
// Purpose: Drives grant and grant_status to the graphics master, gated by buffer-full inputs
// Assumes: Arbitration core presents one request per transfer cycle with cycle_start
// Notes:   Buffer-full levels are latched only at cycle_start; they hold until the next one

`timescale 1ns/10ps
`default_nettype none

// What this block does
// - No low-priority read return granted while read buffer full was sampled.
// - Read buffer full sampled only at start of a transfer cycle.
// - No fast-write data driven while write buffer full was sampled.
// - Write buffer full sampled only at start of a transfer cycle.
// - Status meaningful only with grant; held at start code while idle.
// - Status lines always driven outputs, never tristated.
// - Code 000 with grant means low-priority read data returned.
// - Code 001 is high-priority read in 2.0 mode, never issued in 3.0.
// - Code 011 is high-priority write in 2.0 mode, never issued in 3.0.
// - Grant and buffer-full pins active low in 2.0 mode and active high in 3.0 mode; status pins true sense in both.
module asfc_top (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // Mode: 1 selects 3.0 signalling
   input  wire logic              mode_v3,
   // Request from the arbitration core
   input  wire logic              cycle_start,
   input  wire asfc_pkg::asfc_req_t req_kind,
   // Pins toward the master, at pin polarity
   input  wire logic              read_buffer_full_pin,
   input  wire logic              write_buffer_full_pin,
   output logic                   bus_grant_pin,
   output logic [2:0]             grant_status_pin,
   output logic                   grant_status_oe,
   // Back to the core
   output logic                   req_taken,
   output logic                   fast_wr_go
);

   // Two-stage synchronisers for the master's levels, then the sampled levels, mode and internal state
   logic [1:0]         rbf_sync_q;
   logic [1:0]         wbf_sync_q;
   asfc_pkg::asfc_flow_t flow_q;
   logic               grant_q;
   logic [2:0]         status_q;
   logic               taken_q;
   logic               fwr_q;
   logic               mode_q;
   // Output flops for the grant pin and status enable; status_q, taken_q and fwr_q feed the other outputs
   logic               grant_pin_q;
   logic               oe_q;

   // Master's buffer-full pins cross in through two flops; only the second one is read.
   // The flops clear to 0, which reads as full in 2.0 mode for two edges after reset:
   // a low read or fast write that early is refused, the safe direction, and the core retries it.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rbf_sync_q <= asfc_pkg::SYNC_RST;
         wbf_sync_q <= asfc_pkg::SYNC_RST;
      end else begin
         rbf_sync_q <= {rbf_sync_q[0], read_buffer_full_pin};
         wbf_sync_q <= {wbf_sync_q[0], write_buffer_full_pin};
      end
   end

   // pin polarity: 2.0 mode inverts the active-low pins
   wire rbf_true = rbf_sync_q[1] ^ ~mode_q;
   wire wbf_true = wbf_sync_q[1] ^ ~mode_q;

   // Mode register so polarity cannot change mid-cycle without a clock
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) mode_q <= asfc_pkg::MODE_RST;
      else     mode_q <= mode_v3;
   end

   // sample at start: buffer-full levels latched once per cycle only
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) flow_q <= '0;
      else if (cycle_start) flow_q <= '{rd_full: rbf_true, wr_full: wbf_true};
   end

   // The fresh sample is used in the start cycle itself so a full buffer is never missed
   wire rd_full_now = cycle_start ? rbf_true : flow_q.rd_full;
   wire wr_full_now = cycle_start ? wbf_true : flow_q.wr_full;

   // blocking: full buffers hold back low reads and fast writes
   wire blk_lp_rd  = (req_kind == asfc_pkg::ASFC_REQ_LP_READ) && rd_full_now;
   wire is_fwr     = (req_kind == asfc_pkg::ASFC_REQ_FAST_WR);
   wire blk_fwr    = is_fwr && wr_full_now;
   // reserved in 3.0: high-priority codes refused there
   wire blk_hp     = mode_q && ((req_kind == asfc_pkg::ASFC_REQ_HP_READ) ||
                                (req_kind == asfc_pkg::ASFC_REQ_HP_WRITE));
   // A refused request is dropped, not queued: the core offers it again at a later start
   wire is_idle    = (req_kind == asfc_pkg::ASFC_REQ_IDLE);
   wire accept     = cycle_start && !is_idle && !blk_lp_rd && !blk_fwr && !blk_hp;

   // encoding: only defined codes; reserved ones unreachable
   logic [2:0] code_d;
   always_comb begin
      case (req_kind)
         asfc_pkg::ASFC_REQ_LP_READ:  code_d = asfc_pkg::ST_LP_READ;
         asfc_pkg::ASFC_REQ_HP_READ:  code_d = asfc_pkg::ST_HP_READ;
         asfc_pkg::ASFC_REQ_LP_WRITE: code_d = asfc_pkg::ST_LP_WRITE;
         asfc_pkg::ASFC_REQ_HP_WRITE: code_d = asfc_pkg::ST_HP_WRITE;
         default:                     code_d = asfc_pkg::ST_START;
      endcase
   end

   // Next values; the grant pin uses the mode that mode_q takes at the same edge,
   // so the pin and the internal grant always agree
   wire [2:0] status_d    = accept ? code_d : asfc_pkg::STATUS_RST;
   wire       grant_pin_d = accept ^ ~mode_v3;
   wire       fwr_d       = accept && is_fwr;

   // grant and status: code held one cycle under grant, start code while idle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         grant_q  <= asfc_pkg::GRANT_RST;
         status_q <= asfc_pkg::STATUS_RST;
      end else begin
         grant_q  <= accept;
         status_q <= status_d;
      end
   end

   // Hand-back pulses; a refused request leaves both low so the core retries
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         taken_q <= 1'h0;
         fwr_q   <= 1'h0;
      end else begin
         taken_q <= accept;
         fwr_q   <= fwr_d;
      end
   end

   // grant pin polarity: registered so the pin cannot glitch on a mode change
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) grant_pin_q <= asfc_pkg::GRANT_PIN_RST;
      else     grant_pin_q <= grant_pin_d;
   end

   // status always driven: the enable is a flop held high, reset included
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) oe_q <= asfc_pkg::OE_ON;
      else     oe_q <= asfc_pkg::OE_ON;
   end

   // Every output comes straight from a flop
   assign bus_grant_pin    = grant_pin_q;
   assign grant_status_pin = status_q;
   assign grant_status_oe  = oe_q;
   assign req_taken        = taken_q;
   assign fast_wr_go       = fwr_q;

   // Checks
   ap_lprd_block_a: assert property (@(posedge mclk) disable iff (rst)
      (cycle_start && req_kind == asfc_pkg::ASFC_REQ_LP_READ && rbf_true) |=> !grant_q)
      else $error("low read granted while read buffer full");
   ap_fwr_block_a: assert property (@(posedge mclk) disable iff (rst)
      (cycle_start && req_kind == asfc_pkg::ASFC_REQ_FAST_WR && wbf_true) |=> !fwr_q)
      else $error("fast write started while write buffer full");
   ap_flow_hold_a: assert property (@(posedge mclk) disable iff (rst)
      !cycle_start |=> $stable(flow_q))
      else $error("buffer full sampled outside cycle start");
   ap_no_hp_v3_a: assert property (@(posedge mclk) disable iff (rst)
      (grant_q && $past(mode_q)) |-> (status_q != asfc_pkg::ST_HP_READ))
      else $error("high read code in 3.0 mode");
   ap_no_hpw_v3_a: assert property (@(posedge mclk) disable iff (rst)
      (grant_q && $past(mode_q)) |-> (status_q != asfc_pkg::ST_HP_WRITE))
      else $error("high write code in 3.0 mode");
   ap_no_rsvd_a: assert property (@(posedge mclk) disable iff (rst)
      grant_q |-> (status_q[2] == 1'b0 || status_q == asfc_pkg::ST_START))
      else $error("reserved status code driven");
   ap_status_oe_a: assert property (@(posedge mclk) disable iff (rst)
      grant_status_oe)
      else $error("status not driven");
   ap_grant_pol_a: assert property (@(posedge mclk) disable iff (rst)
      bus_grant_pin == (mode_q ? grant_q : !grant_q))
      else $error("grant polarity wrong");
   ap_lprd_code_a: assert property (@(posedge mclk) disable iff (rst)
      (accept && req_kind == asfc_pkg::ASFC_REQ_LP_READ) |=>
      (grant_q && status_q == asfc_pkg::ST_LP_READ))
      else $error("low read code not issued");
   ap_idle_code_a: assert property (@(posedge mclk) disable iff (rst)
      !grant_q |-> status_q == asfc_pkg::ST_START)
      else $error("idle status not start code");

   // Sampling, code and hand-back checks
   ap_rd_sample_a: assert property (@(posedge mclk) disable iff (rst)
      cycle_start |=> (flow_q.rd_full == $past(rbf_true)))
      else $error("read buffer full not latched at cycle start");
   ap_wr_sample_a: assert property (@(posedge mclk) disable iff (rst)
      cycle_start |=> (flow_q.wr_full == $past(wbf_true)))
      else $error("write buffer full not latched at cycle start");
   ap_hprd_v2_a: assert property (@(posedge mclk) disable iff (rst)
      (accept && !mode_q && req_kind == asfc_pkg::ASFC_REQ_HP_READ) |=>
      (grant_q && status_q == asfc_pkg::ST_HP_READ))
      else $error("high read code not issued in 2.0 mode");
   ap_hpwr_v2_a: assert property (@(posedge mclk) disable iff (rst)
      (accept && !mode_q && req_kind == asfc_pkg::ASFC_REQ_HP_WRITE) |=>
      (grant_q && status_q == asfc_pkg::ST_HP_WRITE))
      else $error("high write code not issued in 2.0 mode");
   ap_start_code_a: assert property (@(posedge mclk) disable iff (rst)
      (accept && req_kind == asfc_pkg::ASFC_REQ_START) |=>
      (grant_q && status_q == asfc_pkg::ST_START))
      else $error("start code not issued");
   ap_fwr_code_a: assert property (@(posedge mclk) disable iff (rst)
      fwr_q |-> (grant_q && status_q == asfc_pkg::ST_START))
      else $error("fast write go without start code under grant");
   ap_idle_refuse_a: assert property (@(posedge mclk) disable iff (rst)
      (cycle_start && is_idle) |=> !grant_q)
      else $error("grant issued for an idle offer");

   cp_lp_read_c:  cover property (@(posedge mclk) disable iff (rst)
      grant_q && status_q == asfc_pkg::ST_LP_READ);
   cp_rd_block_c: cover property (@(posedge mclk) disable iff (rst) blk_lp_rd && cycle_start);
   cp_fast_wr_c:  cover property (@(posedge mclk) disable iff (rst) fwr_q);
   cp_wr_block_c: cover property (@(posedge mclk) disable iff (rst) blk_fwr && cycle_start);
   cp_start_c:    cover property (@(posedge mclk) disable iff (rst)
      grant_q && status_q == asfc_pkg::ST_START);

endmodule

`default_nettype wire

// ### tb/asfc_master_model.sv
// Purpose: Graphics master stand-in that drives the buffer-full pins
// Assumes: Bench commands rd_full and wr_full in true sense
// Notes:   Status is taken only while the grant is seen, as a real master does
`timescale 1ns/10ps
`default_nettype none
module asfc_master_model (
   // Clock and mode
   input  wire logic       mclk,
   input  wire logic       mode_v3,
   // Commands from the bench
   input  wire logic       rd_full,
   input  wire logic       wr_full,
   // Pins from the block
   input  wire logic       bus_grant_pin,
   input  wire logic [2:0] grant_status_pin,
   // Pins to the block, and the last code taken under grant
   output logic            read_buffer_full_pin,
   output logic            write_buffer_full_pin,
   output logic [2:0]      seen_code_q,
   // The master's own queuing, true sense, and the count of requests it queued
   output logic            pipelined_request,
   output logic [7:0]      queued_count
);
   logic [1:0] pipe_left_q = 2'h0;
   logic [7:0] queued_q    = 8'h0;
   wire        granted     = bus_grant_pin ^ ~mode_v3;
   assign read_buffer_full_pin  = rd_full ^ ~mode_v3;
   assign write_buffer_full_pin = wr_full ^ ~mode_v3;
   always_ff @(posedge mclk) begin
      if (granted)
         seen_code_q <= grant_status_pin;
   end
   // start code in 2.0 mode: two requests, one per edge while asserted
   assign pipelined_request = (pipe_left_q != 2'h0);
   assign queued_count      = queued_q;
   always_ff @(posedge mclk) begin
      if (pipelined_request)
         queued_q <= queued_q + 8'h1;
      if (granted && grant_status_pin == 3'h7 && !mode_v3)
         pipe_left_q <= 2'h2;
      else if (pipelined_request)
         pipe_left_q <= pipe_left_q - 2'h1;
   end
endmodule
`default_nettype wire

// ### tb/agp_status_flow_control_tb.sv
// Purpose: Self-checking bench for the status and flow-control block
// Assumes: Outputs settle within 1 ns of the taking edge
// Notes:   Three idle edges after any pin change cover the input synchroniser
`timescale 1ns/10ps
`default_nettype none
module agp_status_flow_control_tb;
   logic                mclk = 0, rst = 1, mode_v3 = 0, cycle_start = 0, rd_full = 0, wr_full = 0;
   asfc_pkg::asfc_req_t req_kind = asfc_pkg::ASFC_REQ_IDLE;
   logic                rbf_pin, wbf_pin, grant_pin, oe, req_taken, fast_wr_go, pipe_req;
   logic [2:0]          status_pin, seen_code;
   logic [7:0]          queued;
   int                  n_errors = 0, check_count = 0;
   always #5 mclk = ~mclk;
   asfc_top dut (.mclk(mclk), .rst(rst), .mode_v3(mode_v3), .cycle_start(cycle_start),
      .req_kind(req_kind), .read_buffer_full_pin(rbf_pin), .write_buffer_full_pin(wbf_pin),
      .bus_grant_pin(grant_pin), .grant_status_pin(status_pin), .grant_status_oe(oe),
      .req_taken(req_taken), .fast_wr_go(fast_wr_go));
   asfc_master_model master (.mclk(mclk), .mode_v3(mode_v3), .rd_full(rd_full),
      .wr_full(wr_full), .bus_grant_pin(grant_pin), .grant_status_pin(status_pin),
      .read_buffer_full_pin(rbf_pin), .write_buffer_full_pin(wbf_pin), .seen_code_q(seen_code),
      .pipelined_request(pipe_req), .queued_count(queued));
   // Compare and count
   task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      if (n_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Mode and master buffer state, then let the synchroniser catch up
   task automatic setup(input logic m, input logic rf, input logic wf);
      mode_v3 = m;
      rd_full = rf;
      wr_full = wf;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   // One request; judged the cycle after it, then idle is judged
   task automatic issue(input asfc_pkg::asfc_req_t k, input logic tk, input logic [2:0] code);
      @(posedge mclk) #1;
      cycle_start = 1;
      req_kind = k;
      @(posedge mclk) #1;
      cycle_start = 0;
      req_kind = asfc_pkg::ASFC_REQ_IDLE;
      check("req_taken", {3'h0, req_taken}, {3'h0, tk});
      check("grant_pin", {3'h0, grant_pin}, {3'h0, tk ^ ~mode_v3});
      check("status", {1'h0, status_pin}, {1'h0, tk ? code : 3'h7});
      check("fast_wr_go", {3'h0, fast_wr_go}, {3'h0, tk && k == asfc_pkg::ASFC_REQ_FAST_WR});
      check("oe", {3'h0, oe}, 4'h1);
      @(posedge mclk) #1;
      if (tk)
         check("master_code", {1'h0, seen_code}, {1'h0, code});
      check("idle_grant", {3'h0, grant_pin}, {3'h0, ~mode_v3});
   endtask
   // Every request kind except fast write, with buffers free
   task automatic t_codes(input logic m);
      logic [7:0] base;
      setup(m, 1'h0, 1'h0);
      issue(asfc_pkg::ASFC_REQ_IDLE, 1'h0, 3'h7);
      issue(asfc_pkg::ASFC_REQ_LP_READ, 1'h1, 3'h0);
      issue(asfc_pkg::ASFC_REQ_HP_READ, ~m, 3'h1);
      issue(asfc_pkg::ASFC_REQ_LP_WRITE, 1'h1, 3'h2);
      issue(asfc_pkg::ASFC_REQ_HP_WRITE, ~m, 3'h3);
      issue(asfc_pkg::ASFC_REQ_START, 1'h1, 3'h7);
      // The start grant lets a 2.0 master queue its two requests; none in 3.0
      base = queued;
      repeat (3) @(posedge mclk);
      #1;
      check("queued", 4'(queued - base), m ? 4'h0 : 4'h2);
      check("pipe_req", {3'h0, pipe_req}, 4'h0);
   endtask
   // Read buffer full holds back low reads only, then frees them
   task automatic t_rd_full(input logic m);
      setup(m, 1'h1, 1'h0);
      issue(asfc_pkg::ASFC_REQ_LP_READ, 1'h0, 3'h0);
      issue(asfc_pkg::ASFC_REQ_FAST_WR, 1'h1, 3'h7);
      setup(m, 1'h0, 1'h0);
      issue(asfc_pkg::ASFC_REQ_LP_READ, 1'h1, 3'h0);
   endtask
   // Write buffer full holds back fast writes only
   task automatic t_wr_full(input logic m);
      setup(m, 1'h0, 1'h1);
      issue(asfc_pkg::ASFC_REQ_FAST_WR, 1'h0, 3'h7);
      issue(asfc_pkg::ASFC_REQ_LP_READ, 1'h1, 3'h0);
      setup(m, 1'h0, 1'h0);
      issue(asfc_pkg::ASFC_REQ_FAST_WR, 1'h1, 3'h7);
   endtask
   // Reset in mid-run during a grant: status returns to start code 7, req_taken and fast_wr_go clear, the grant pin goes to 1 (asserted in 3.0), then traffic resumes
   task automatic t_reset();
      setup(1'h1, 1'h0, 1'h0);
      @(posedge mclk) #1;
      cycle_start = 1;
      req_kind = asfc_pkg::ASFC_REQ_LP_READ;
      @(posedge mclk) #1;
      cycle_start = 0;
      req_kind = asfc_pkg::ASFC_REQ_IDLE;
      check("pre_rst_taken", {3'h0, req_taken}, 4'h1);
      rst = 1;
      @(posedge mclk) #1;
      check("mid_rst_grant", {3'h0, grant_pin}, 4'h1);
      check("mid_rst_status", {1'h0, status_pin}, 4'h7);
      check("mid_rst_taken", {3'h0, req_taken}, 4'h0);
      check("mid_rst_fwr", {3'h0, fast_wr_go}, 4'h0);
      check("mid_rst_oe", {3'h0, oe}, 4'h1);
      @(posedge mclk) #1;
      rst = 0;
      @(posedge mclk) #1;
      check("post_rst_grant", {3'h0, grant_pin}, 4'h0);
      issue(asfc_pkg::ASFC_REQ_LP_READ, 1'h1, 3'h0);
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      #1;
      check("rst_status", {1'h0, status_pin}, 4'h7);
      rst = 0;
      for (int m = 0; m < 2; m++) begin
         t_codes(m[0]);
         t_rd_full(m[0]);
         t_wr_full(m[0]);
      end
      t_reset();
      close_out();
   end
endmodule
`default_nettype wire
